// >>> verilog/ddcrm_pkg.sv
// Purpose: Shared constants and state types of the downconverter
//          control register bank.
// Assumes: Byte-wide registers, each at byte address four times its index.
// Notes:   Every offset, mask and reset value used by the bank sits here.
package ddcrm_pkg;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_DECIMATION_LOW = 8'h00;
  localparam logic [7:0] IDX_DECIMATION_HIGH_AND_MODE = 8'h01;
  localparam logic [7:0] IDX_SCALE = 8'h02;
  localparam logic [7:0] IDX_CHAN_A_FIRST_GAIN = 8'h03;
  localparam logic [7:0] IDX_CHAN_B_FIRST_GAIN = 8'h04;
  localparam logic [7:0] IDX_RATE = 8'h05;
  localparam logic [7:0] IDX_SERIAL_OUTPUT_CONTROL = 8'h06;
  localparam logic [7:0] IDX_CHAN_A_TUNING_WORD = 8'h07;
  localparam logic [7:0] IDX_CHAN_A_PHASE_OFFSET = 8'h0b;
  localparam logic [7:0] IDX_CHAN_B_TUNING_WORD = 8'h0d;
  localparam logic [7:0] IDX_CHAN_B_PHASE_OFFSET = 8'h11;
  localparam logic [7:0] IDX_INPUT_CROSSBAR_SELECT = 8'h13;
  localparam logic [7:0] IDX_GAIN_LOOP_CONTROL = 8'h14;
  localparam logic [7:0] IDX_GAIN_LOOP_HOLD_COUNT = 8'h15;
  localparam logic [7:0] IDX_CHAN_A_INTEGRATOR_INIT = 8'h17;
  localparam logic [7:0] IDX_CHAN_B_INTEGRATOR_INIT = 8'h18;
  localparam logic [7:0] IDX_CHAN_A_INTEGRATOR_READBACK = 8'h19;
  localparam logic [7:0] IDX_CHAN_B_INTEGRATOR_READBACK = 8'h1a;
  localparam logic [7:0] IDX_TEST_INPUT_SAMPLE = 8'h1b;
  localparam logic [7:0] IDX_TEST_INPUT_SAMPLE_HIGH = 8'h1c;
  localparam logic [7:0] IDX_RESERVED_LOW = 8'h1d;
  localparam logic [7:0] IDX_RESERVED_HIGH = 8'h1e;
  localparam logic [7:0] IDX_DEBUG_AND_DITHER = 8'h1f;
  localparam logic [7:0] IDX_GAIN_LOOP_LOOKUP_RAM = 8'h80;
  localparam logic [7:0] IDX_FIRST_FIR_TAPS = 8'ha0;
  localparam logic [7:0] IDX_SECOND_FIR_TAPS = 8'hb6;
  localparam logic [7:0] IDX_RAM_LAST = 8'hf5;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int CFG_BYTES = 32;
  localparam int RAM_BYTES = 118;
  localparam int LOOKUP_ENTRIES = 32;
  localparam int FIRST_TAPS = 11;
  localparam int SECOND_TAPS = 32;
  localparam int FIRST_TAP_BASE = 32;
  localparam int SECOND_TAP_BASE = 54;
  localparam int ADDR_INDEX_LSB = 2;

  // ---------------------------------------------------------------
  // Field positions, writable masks and reset values
  // ---------------------------------------------------------------
  localparam int DITHER_A_BIT = 6;
  localparam int DITHER_B_BIT = 7;
  localparam logic [7:0] MASK_DECIMATION_HIGH = 8'h17;
  localparam logic [7:0] MASK_SCALE = 8'h3f;
  localparam logic [7:0] MASK_FIRST_GAIN = 8'h07;
  localparam logic [7:0] MASK_CROSSBAR = 8'h0f;
  localparam logic [7:0] MASK_GAIN_LOOP_CONTROL = 8'h3f;
  localparam logic [7:0] MASK_TEST_HIGH = 8'h3f;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_DEBUG_AND_DITHER = 8'hc0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------
  // State of the register bank
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CFG_BYTES-1:0][7:0] cfg;
    logic [RAM_BYTES-1:0][7:0] ram;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic sync_seen;
    logic sync_pulse;
  } ddcrm_state_t;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } ddcrm_sync_state_t;

endpackage

// >>> verilog/ddcrm_sync.sv
// Purpose: Two flip-flop synchroniser for a level arriving from a pin.
// Assumes: Single clock, synchronous active high reset.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/10ps
`default_nettype none

module ddcrm_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Synchronous reset
  input wire logic async_i, // Pin level
  output logic sync_o // Synchronised level
);

  ddcrm_pkg::ddcrm_sync_state_t state_q;
  ddcrm_pkg::ddcrm_sync_state_t state_d;

  always_comb begin
    state_d.stage1 = async_i;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q.stage1 <= RESET_LEVEL;
      state_q.stage2 <= RESET_LEVEL;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_o = state_q.stage2;

endmodule // ddcrm_sync

`default_nettype wire

// >>> verilog/ddcrm_regs.sv
// Purpose: Control register bank of a dual-channel downconverter: byte
//          registers, gain-loop lookup table and both filter tap RAMs,
//          reached over APB.
// Assumes: 100 MHz clk_i; APB master on the same clock; master reset and
//          sync pins are asynchronous and get synchronised here.
// Notes:   One byte per 32-bit word, in bits 7:0; upper bits read zero.
//
// Operation
// (R1) Channel B dither enable, bit 7, resets 1
// (R2) 32-byte shared lookup RAM at 128..159
// (R3) First filter: eleven 16-bit taps, 160..181
// (R4) First filter low byte at lower address
// (R5) Second filter: thirty-two 16-bit taps, 182..245
// (R6) Second filter low byte at even address
// (R7) Master reset loads all defaults, tables zero
// (R8) Sync input leaves every register unchanged
// (R9) Channel A dither enable, bit 6, resets 1
// (R10) Byte write changes only the addressed byte
`timescale 1ns/10ps
`default_nettype none

module ddcrm_regs (
  input wire logic clk_i, // Clock, 100 MHz
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic master_reset_n_i, // Master reset pin, active low
  input wire logic sync_n_i, // Sync-in pin, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  output logic [31:0] prdata, // APB read data
  input wire logic [7:0] chan_a_integrator_i, // Gain loop A readback
  input wire logic [7:0] chan_b_integrator_i, // Gain loop B readback
  output logic chan_a_dither_enable_o, // Oscillator dither, channel A
  output logic chan_b_dither_enable_o, // Oscillator dither, channel B
  output logic [31:0] chan_a_tuning_word_o, // Tuning word A
  output logic [31:0] chan_b_tuning_word_o, // Tuning word B
  output logic [15:0] chan_a_phase_offset_o, // Phase offset A
  output logic [15:0] chan_b_phase_offset_o, // Phase offset B
  output logic [31:0][7:0] lookup_table_o, // Gain-loop lookup table
  output logic [10:0][15:0] first_fir_taps_o, // First filter taps
  output logic [31:0][15:0] second_fir_taps_o, // Second filter taps
  output logic sync_pulse_o // One-cycle pulse on sync falling
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic master_reset_n_s;
  logic sync_n_s;

  ddcrm_sync #(.RESET_LEVEL(1'b1)) u_mr_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(master_reset_n_i),
    .sync_o(master_reset_n_s)
  );

  ddcrm_sync #(.RESET_LEVEL(1'b1)) u_si_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(sync_n_i),
    .sync_o(sync_n_s)
  );

  // ---------------------------------------------------------------
  // Address decode helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] write_mask(input logic [7:0] idx);
    logic [7:0] m;
    m = ddcrm_pkg::MASK_FULL;
    case (idx)
      ddcrm_pkg::IDX_DECIMATION_HIGH_AND_MODE: begin
        m = ddcrm_pkg::MASK_DECIMATION_HIGH;
      end
      ddcrm_pkg::IDX_SCALE: begin
        m = ddcrm_pkg::MASK_SCALE;
      end
      ddcrm_pkg::IDX_CHAN_A_FIRST_GAIN,
      ddcrm_pkg::IDX_CHAN_B_FIRST_GAIN: begin
        m = ddcrm_pkg::MASK_FIRST_GAIN;
      end
      ddcrm_pkg::IDX_INPUT_CROSSBAR_SELECT: begin
        m = ddcrm_pkg::MASK_CROSSBAR;
      end
      ddcrm_pkg::IDX_GAIN_LOOP_CONTROL: begin
        m = ddcrm_pkg::MASK_GAIN_LOOP_CONTROL;
      end
      ddcrm_pkg::IDX_TEST_INPUT_SAMPLE_HIGH: begin
        m = ddcrm_pkg::MASK_TEST_HIGH;
      end
      // Readback bytes are driven by the gain loop, not by software
      ddcrm_pkg::IDX_CHAN_A_INTEGRATOR_READBACK,
      ddcrm_pkg::IDX_CHAN_B_INTEGRATOR_READBACK: begin
        m = ddcrm_pkg::RESET_BYTE;
      end
      default: begin
        m = ddcrm_pkg::MASK_FULL;
      end
    endcase
    return m;
  endfunction

  ddcrm_pkg::ddcrm_state_t state_q;
  ddcrm_pkg::ddcrm_state_t state_d;

  logic [7:0] idx;
  logic upper_clear;
  logic in_cfg;
  logic in_ram;
  logic mapped;
  logic [7:0] ram_idx;
  logic [7:0] cfg_byte;
  logic [7:0] ram_byte;
  logic [7:0] rd_byte;
  logic [7:0] mask;
  logic setup_phase;
  logic commit_write;

  always_comb begin
    idx = paddr[ddcrm_pkg::ADDR_INDEX_LSB +: 8];
    upper_clear = (paddr[31:10] == 22'h00_0000) && (paddr[1:0] == 2'b00);
    in_cfg = (idx < ddcrm_pkg::IDX_GAIN_LOOP_LOOKUP_RAM) &&
             (idx <= ddcrm_pkg::IDX_DEBUG_AND_DITHER) &&
             (idx != ddcrm_pkg::IDX_RESERVED_LOW) &&
             (idx != ddcrm_pkg::IDX_RESERVED_HIGH);
    in_ram = (idx >= ddcrm_pkg::IDX_GAIN_LOOP_LOOKUP_RAM) && // R2 R3 R5
             (idx <= ddcrm_pkg::IDX_RAM_LAST);
    mapped = upper_clear && (in_cfg || in_ram);
    ram_idx = idx - ddcrm_pkg::IDX_GAIN_LOOP_LOOKUP_RAM;
    cfg_byte = state_q.cfg[idx[4:0]];
    ram_byte = in_ram ? state_q.ram[ram_idx[6:0]] : ddcrm_pkg::RESET_BYTE;
    mask = write_mask(idx);
  end

  // ---------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------
  always_comb begin
    rd_byte = ddcrm_pkg::RESET_BYTE;
    if (in_ram) begin
      rd_byte = ram_byte;
    end else if (idx == ddcrm_pkg::IDX_CHAN_A_INTEGRATOR_READBACK) begin
      rd_byte = chan_a_integrator_i;
    end else if (idx == ddcrm_pkg::IDX_CHAN_B_INTEGRATOR_READBACK) begin
      rd_byte = chan_b_integrator_i;
    end else if (in_cfg) begin
      rd_byte = cfg_byte;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // The access phase always lasts one cycle: ready and read data are
  // prepared during setup so that every bus output comes from a flop.
  always_comb begin
    state_d = state_q;
    setup_phase = psel && !penable;
    commit_write = psel && penable && state_q.ready && pwrite &&
                   mapped && pstrb[0];
    state_d.ready = setup_phase;
    state_d.slverr = setup_phase && !mapped;
    state_d.rdata = ddcrm_pkg::READ_ZERO;
    if (setup_phase && !pwrite && mapped) begin
      state_d.rdata = {24'h00_0000, rd_byte};
    end
    if (commit_write) begin
      if (in_ram) begin
        state_d.ram[ram_idx[6:0]] = pwdata[7:0]; // R4 R6 R10
      end else begin
        state_d.cfg[idx[4:0]] = (cfg_byte & ~mask) | // R10
                                (pwdata[7:0] & mask);
      end
    end
    // Sync only marks an event for the datapath; registers stay put.
    state_d.sync_seen = !sync_n_s; // R8
    state_d.sync_pulse = !sync_n_s && !state_q.sync_seen; // R8
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i || !master_reset_n_s) begin
      state_q.cfg <= '0; // R7
      state_q.cfg[ddcrm_pkg::IDX_DEBUG_AND_DITHER[4:0]] <=
        ddcrm_pkg::RESET_DEBUG_AND_DITHER; // R1 R9
      state_q.ram <= '0; // R7
      state_q.ready <= 1'b0;
      state_q.slverr <= 1'b0;
      state_q.rdata <= ddcrm_pkg::READ_ZERO;
      state_q.sync_seen <= 1'b0;
      state_q.sync_pulse <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all taken from flops
  // ---------------------------------------------------------------
  assign pready = state_q.ready;
  assign pslverr = state_q.slverr;
  assign prdata = state_q.rdata;
  assign sync_pulse_o = state_q.sync_pulse;
  assign chan_a_dither_enable_o =
    state_q.cfg[ddcrm_pkg::IDX_DEBUG_AND_DITHER[4:0]]
               [ddcrm_pkg::DITHER_A_BIT]; // R9
  assign chan_b_dither_enable_o =
    state_q.cfg[ddcrm_pkg::IDX_DEBUG_AND_DITHER[4:0]]
               [ddcrm_pkg::DITHER_B_BIT]; // R1

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tuning
      assign chan_a_tuning_word_o[8*g +: 8] =
        state_q.cfg[ddcrm_pkg::IDX_CHAN_A_TUNING_WORD[4:0] + g];
      assign chan_b_tuning_word_o[8*g +: 8] =
        state_q.cfg[ddcrm_pkg::IDX_CHAN_B_TUNING_WORD[4:0] + g];
    end
    for (g = 0; g < 2; g++) begin : g_phase
      assign chan_a_phase_offset_o[8*g +: 8] =
        state_q.cfg[ddcrm_pkg::IDX_CHAN_A_PHASE_OFFSET[4:0] + g];
      assign chan_b_phase_offset_o[8*g +: 8] =
        state_q.cfg[ddcrm_pkg::IDX_CHAN_B_PHASE_OFFSET[4:0] + g];
    end
    for (g = 0; g < ddcrm_pkg::LOOKUP_ENTRIES; g++) begin : g_lookup
      assign lookup_table_o[g] = state_q.ram[g]; // R2
    end
    for (g = 0; g < ddcrm_pkg::FIRST_TAPS; g++) begin : g_first
      assign first_fir_taps_o[g] = { // R3 R4
        state_q.ram[ddcrm_pkg::FIRST_TAP_BASE + 2*g + 1],
        state_q.ram[ddcrm_pkg::FIRST_TAP_BASE + 2*g]};
    end
    for (g = 0; g < ddcrm_pkg::SECOND_TAPS; g++) begin : g_second
      assign second_fir_taps_o[g] = { // R5 R6
        state_q.ram[ddcrm_pkg::SECOND_TAP_BASE + 2*g + 1],
        state_q.ram[ddcrm_pkg::SECOND_TAP_BASE + 2*g]};
    end
  endgenerate

endmodule // ddcrm_regs

`default_nettype wire

// >>> testbench/ddcrm_regs_checker.sv
// Purpose: Port-level assertions for the downconverter register bank.
// Assumes: One clock; APB slave answers in the cycle after setup.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/10ps
`default_nettype none

module ddcrm_regs_checker (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Synchronous reset
  input wire logic master_reset_n_i, // Master reset pin
  input wire logic sync_n_i, // Sync-in pin
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [31:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic chan_a_dither_enable_o, // Dither A
  input wire logic chan_b_dither_enable_o, // Dither B
  input wire logic [31:0] chan_a_tuning_word_o, // Tuning word A
  input wire logic [31:0][7:0] lookup_table_o, // Lookup table
  input wire logic [10:0][15:0] first_fir_taps_o, // First taps
  input wire logic [31:0][15:0] second_fir_taps_o // Second taps
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic commit;
  assign commit = psel && penable && pready && pwrite && pstrb[0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence mr_hold_s;
    !master_reset_n_i [*3];
  endsequence
  // Four idle cycles so no write or master reset can explain a change
  sequence quiet_s;
    (!psel && master_reset_n_i && !sync_n_i) [*4];
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or too long");
  hole_error_a: assert property (setup_s ##0 paddr[9:2] == 8'h1d |=> pslverr)
    else $error("reserved index gave no error");
  ram_mapped_a: assert property (setup_s ##0 paddr[9:2] >= 8'h80
    ##0 paddr[9:2] <= 8'hf5 |=> !pslverr) else $error("table index refused");
  dither_b_a: assert property (commit && paddr == 32'h0000_007c
    |=> chan_b_dither_enable_o == $past(pwdata[7])) else $error("dither b");
  dither_a_a: assert property (commit && paddr == 32'h0000_007c
    |=> chan_a_dither_enable_o == $past(pwdata[6])) else $error("dither a");
  first_low_a: assert property (commit && paddr == 32'h0000_0280
    |=> first_fir_taps_o[0][7:0] == $past(pwdata[7:0]))
    else $error("first tap low byte");
  second_high_a: assert property (commit && paddr == 32'h0000_02dc
    |=> second_fir_taps_o[0][15:8] == $past(pwdata[7:0]))
    else $error("second tap high byte");
  master_dflt_a: assert property (mr_hold_s |=> chan_a_dither_enable_o
    && chan_b_dither_enable_o && lookup_table_o == '0
    && first_fir_taps_o == '0 && second_fir_taps_o == '0)
    else $error("master reset defaults");
  sync_keep_a: assert property (quiet_s |-> $stable(lookup_table_o)
    && $stable(chan_a_tuning_word_o) && $stable(chan_b_dither_enable_o))
    else $error("sync changed a register");
endmodule // ddcrm_regs_checker

bind ddcrm_regs ddcrm_regs_checker ddcrm_regs_checker_i (
  .clk_i(clk_i), .reset_i(reset_i), .master_reset_n_i(master_reset_n_i),
  .sync_n_i(sync_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .chan_a_dither_enable_o(chan_a_dither_enable_o),
  .chan_b_dither_enable_o(chan_b_dither_enable_o),
  .chan_a_tuning_word_o(chan_a_tuning_word_o),
  .lookup_table_o(lookup_table_o), .first_fir_taps_o(first_fir_taps_o),
  .second_fir_taps_o(second_fir_taps_o));
`default_nettype wire

// >>> testbench/test_ddc_control_register_map.sv
// Purpose: Self-checking bench for the downconverter register bank.
// Assumes: APB slave, one byte register per word, byte in bits 7:0.
// Notes:   Byte address is four times the register index.
`timescale 1ns/10ps
`default_nettype none

module test_ddc_control_register_map;
  logic clk_i, reset_i, master_reset_n_i, sync_n_i;
  logic psel, penable, pwrite, pready, pslverr, chan_a_dither_enable, chan_b_dither_enable, err;
  logic [31:0] paddr, pwdata, prdata, ta, rd;
  logic [3:0] pstrb;
  logic [7:0] int_a, int_b;
  logic [31:0] tb;
  logic [15:0] pa, pb;
  logic sp;
  int n_pulse = 0;
  logic [31:0][7:0] lut;
  logic [10:0][15:0] f1;
  logic [31:0][15:0] f2;
  int n_errors, checked;

  ddcrm_regs ddcrm_regs_i (
    .clk_i(clk_i), .reset_i(reset_i), .master_reset_n_i(master_reset_n_i),
    .sync_n_i(sync_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .chan_a_integrator_i(int_a),
    .chan_b_integrator_i(int_b), .chan_a_dither_enable_o(chan_a_dither_enable),
    .chan_b_dither_enable_o(chan_b_dither_enable), .chan_a_tuning_word_o(ta),
    .chan_b_tuning_word_o(tb), .chan_a_phase_offset_o(pa),
    .chan_b_phase_offset_o(pb), .lookup_table_o(lut),
    .first_fir_taps_o(f1), .second_fir_taps_o(f2), .sync_pulse_o(sp));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Starts right after an edge; leaves one idle cycle so no strobe is
  // assigned twice in one time step
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h00_0000, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk_i);
    penable <= 1'b1;
    // No cycle count is assumed: pready ends this wait, or else the watchdog
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Counts cycles with the sync pulse high; it must stand one cycle
  always @(posedge clk_i) begin
    if (sp === 1'b1) begin
      n_pulse++;
    end
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    close_out();
  end
  initial begin
    n_errors = 0;
    checked = 0;
    {reset_i, master_reset_n_i, sync_n_i} = 3'b111;
    {psel, penable, pwrite} = 3'b000;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h1;
    int_a = 8'h5a;
    int_b = 8'ha5;
    // Two edges of reset load both synchroniser stages
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rdc(8'h1f, 8'hc0);
    chk({30'h0000_0000, chan_b_dither_enable, chan_a_dither_enable}, 32'h0000_0003);
    rdc(8'h80, 8'h00);
    rdc(8'hf5, 8'h00);
    wr(8'h19, 8'h00);
    rdc(8'h19, 8'h5a);
    rdc(8'h1a, 8'ha5);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h1f, {i[1:0], 6'h00});
      chk({30'h0000_0000, chan_b_dither_enable, chan_a_dither_enable}, i);
    end
    $display("test dither done");
    wr(8'h80, 8'h81);
    wr(8'h9f, 8'h7f);
    rdc(8'h80, 8'h81);
    rdc(8'h9f, 8'h7f);
    chk({24'h00_0000, lut[0]}, 32'h0000_0081);
    chk({24'h00_0000, lut[31]}, 32'h0000_007f);
    apb(1'b0, 8'h1d, 8'h00);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, 8'hf6, 8'h55);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    $display("test lookup done");
    wr(8'ha0, 8'h34);
    wr(8'ha1, 8'h12);
    wr(8'hb4, 8'hcd);
    wr(8'hb5, 8'hab);
    wr(8'hb6, 8'h78);
    wr(8'hb7, 8'h56);
    wr(8'hf4, 8'hef);
    wr(8'hf5, 8'h9e);
    chk({16'h0000, f1[0]}, 32'h0000_1234);
    chk({16'h0000, f1[10]}, 32'h0000_abcd);
    chk({16'h0000, f2[0]}, 32'h0000_5678);
    chk({16'h0000, f2[31]}, 32'h0000_9eef);
    rdc(8'hb5, 8'hab);
    $display("test taps done");
    wr(8'h07, 8'h11);
    wr(8'h08, 8'h22);
    wr(8'h09, 8'h33);
    wr(8'h0a, 8'h44);
    wr(8'h08, 8'h99);
    chk(ta, 32'h4433_9911);
    rdc(8'h09, 8'h33);
    wr(8'h0b, 8'h21);
    wr(8'h0c, 8'h43);
    wr(8'h11, 8'h65);
    wr(8'h12, 8'h87);
    for (int i = 0; i < 4; i++) begin
      wr(8'h0d + i[7:0], 8'hb0 + i[7:0]);
    end
    chk({16'h0000, pa}, 32'h0000_4321);
    chk({16'h0000, pb}, 32'h0000_8765);
    chk(tb, 32'hb3b2_b1b0);
    wr(8'h02, 8'hff);
    rdc(8'h02, 8'h3f);
    pstrb <= 4'h0;
    wr(8'h00, 8'h5a);
    pstrb <= 4'h1;
    rdc(8'h00, 8'h00);
    $display("test byte write done");
    sync_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    sync_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(ta, 32'h4433_9911);
    chk({16'h0000, f1[0]}, 32'h0000_1234);
    rdc(8'h1f, 8'hc0);
    chk(n_pulse, 32'h0000_0001);
    $display("test sync done");
    master_reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    master_reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(ta, 32'h0000_0000);
    chk(tb, 32'h0000_0000);
    chk({16'h0000, pa}, 32'h0000_0000);
    chk(n_pulse, 32'h0000_0001);
    chk({24'h00_0000, lut[31]}, 32'h0000_0000);
    chk({16'h0000, f1[10]}, 32'h0000_0000);
    chk({16'h0000, f2[31]}, 32'h0000_0000);
    rdc(8'h1f, 8'hc0);
    $display("test master reset done");
    close_out();
  end
endmodule // test_ddc_control_register_map
`default_nettype wire
